// ==== rtl/cfs_cache_flush_sequencer.sv ====
`timescale 1ns/1ns

module cfs_cache_flush_sequencer #(
    parameter int unsigned SETS = 64,
    parameter int unsigned WAYS = 4
) (
    // Clock and reset
    input  wire logic                     ref_clk_i,
    input  wire logic                     srst_i,
    // Avalon-MM register slave
    input  wire logic [4:0]               avs_address_i,
    input  wire logic                     avs_read_i,
    input  wire logic                     avs_write_i,
    input  wire logic [31:0]              avs_writedata_i,
    input  wire logic [3:0]               avs_byteenable_i,
    output logic      [31:0]              avs_readdata_o,
    output logic                          avs_waitrequest_o,
    // Per-line requests to the cache arrays
    output logic                          op_valid_o,
    output logic      [$clog2(SETS*WAYS)-1:0] op_index_o,
    output cfs_pkg::cfs_line_op_t         op_o,
    input  wire logic                     op_ack_i,
    input  wire logic                     op_err_i,
    // Prefetch cancel at a zero-position start
    output cfs_pkg::cfs_pf_flush_t        pf_flush_o,
    // Interrupt controller side
    input  wire logic                     irq_pending_i,
    input  wire logic [cfs_pkg::VEC_W-1:0] irq_vector_i,
    output logic                          irq_ack_o,
    input  wire logic                     platform_mgmt_irq_i,
    // Call state
    output logic                          busy_o
);

    localparam int unsigned LINES = SETS * WAYS;
    localparam int unsigned IDXW  = $clog2(LINES);
    localparam logic [IDXW-1:0] IDX_LAST = IDXW'(LINES - 1);

    typedef struct packed {
        cfs_pkg::cfs_fsm_t                 fsm;
        logic [IDXW-1:0]                   idx;
        logic [cfs_pkg::CMD_TGT_W-1:0]     tgt;
        logic                              inv;
        logic                              poll;
        logic [cfs_pkg::PROG_W-1:0]        prog;
        logic [cfs_pkg::STAT_CODE_W-1:0]   status;
        logic [cfs_pkg::VEC_W-1:0]         vector;
        logic                              mgmt_seen;
        logic                              busy;
        logic                              op_valid;
        cfs_pkg::cfs_line_op_t             op;
        cfs_pkg::cfs_pf_flush_t            pf;
        logic                              irq_ack;
        logic                              ack;
        logic                              waitreq;
        logic [31:0]                       rdata;
    } cfs_state_t;

    cfs_state_t q;
    cfs_state_t d;

    logic                         wr_go;
    logic                         start_go;
    logic [cfs_pkg::CMD_TGT_W-1:0] wr_tgt;
    logic                         tgt_ok;
    logic                         prog_ok;
    logic                         line_done;

    function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Which arrays a line step touches, fixed for the whole pass.
    function automatic cfs_pkg::cfs_line_op_t op_of(input logic [7:0] tgt,
                                                    input logic       inv);
        cfs_pkg::cfs_line_op_t o;
        o.sel_icache   = (tgt != cfs_pkg::TGT_DATA);
        o.sel_dcache   = (tgt != cfs_pkg::TGT_INSTR);
        o.sel_ucache   = 1'b1;
        // Instruction lines hold nothing modified, so dropping them is always safe
        // and also discards stale prefetched code.
        o.inv_icache   = 1'b1;
        o.inv_data     = inv && (tgt != cfs_pkg::TGT_COHERE);
        o.bcast_data   = 1'b1;
        o.bcast_icache = 1'b0;
        return o;
    endfunction

    // Write buffers are not drained here; software flushes them separately.
    assign wr_go     = q.ack && avs_write_i;
    assign wr_tgt    = avs_writedata_i[cfs_pkg::CMD_TGT_LSB +: cfs_pkg::CMD_TGT_W];
    assign tgt_ok    = (wr_tgt >= cfs_pkg::TGT_INSTR) && (wr_tgt <= cfs_pkg::TGT_COHERE);
    // A position past the last line cannot have been returned by us.
    assign prog_ok   = (q.prog < cfs_pkg::PROG_W'(LINES));
    assign start_go  = wr_go && (avs_address_i == cfs_pkg::OFS_CMD)
                       && (q.fsm == cfs_pkg::CFS_IDLE);
    assign line_done = (q.fsm == cfs_pkg::CFS_RUN) && op_ack_i;

    always_comb begin
        d         = q;
        d.irq_ack = 1'b0;
        d.pf      = '0;

        // One wait cycle per access, then a single cycle with waitrequest low.
        // The fixed wait state keeps read data registered, at one cycle per access.
        if (q.ack) begin
            d.ack     = 1'b0;
            d.waitreq = 1'b1;
        end else if (avs_read_i || avs_write_i) begin
            d.ack     = 1'b1;
            d.waitreq = 1'b0;
            d.rdata   = '0;
            if (avs_read_i) begin
                unique case (avs_address_i)
                    cfs_pkg::OFS_CMD: begin
                        d.rdata[cfs_pkg::CMD_TGT_LSB +: cfs_pkg::CMD_TGT_W] = q.tgt;
                        d.rdata[cfs_pkg::CMD_INV_BIT]  = q.inv;
                        d.rdata[cfs_pkg::CMD_POLL_BIT] = q.poll;
                    end
                    cfs_pkg::OFS_PROG_LO: d.rdata = q.prog[31:0];
                    cfs_pkg::OFS_PROG_HI: d.rdata = q.prog[63:32];
                    cfs_pkg::OFS_STATUS: begin
                        d.rdata[cfs_pkg::STAT_CODE_W-1:0] = q.status;
                        d.rdata[cfs_pkg::STAT_BUSY_BIT]   = (q.fsm == cfs_pkg::CFS_RUN);
                        d.rdata[cfs_pkg::STAT_MGMT_BIT]   = q.mgmt_seen;
                    end
                    cfs_pkg::OFS_VECTOR: d.rdata[cfs_pkg::VEC_W-1:0] = q.vector;
                    default: d.rdata = '0;
                endcase
            end
        end

        if (wr_go && avs_address_i == cfs_pkg::OFS_PROG_LO) begin
            d.prog[31:0] = merge_be(q.prog[31:0], avs_writedata_i, avs_byteenable_i);
        end
        if (wr_go && avs_address_i == cfs_pkg::OFS_PROG_HI) begin
            d.prog[63:32] = merge_be(q.prog[63:32], avs_writedata_i, avs_byteenable_i);
        end

        // A command written while a pass runs is ignored.
        if (start_go) begin
            d.tgt  = wr_tgt;
            d.inv  = avs_writedata_i[cfs_pkg::CMD_INV_BIT];
            d.poll = avs_writedata_i[cfs_pkg::CMD_POLL_BIT];
            if (!tgt_ok || !prog_ok) begin
                d.status = cfs_pkg::ST_BADARG;
            end else begin
                d.fsm      = cfs_pkg::CFS_RUN;
                d.op_valid = 1'b1;
                d.op       = op_of(wr_tgt, avs_writedata_i[cfs_pkg::CMD_INV_BIT]);
                if (q.prog == '0) begin
                    d.idx      = '0;
                    d.mgmt_seen = 1'b0;
                    d.pf.instr = (wr_tgt != cfs_pkg::TGT_DATA);
                    d.pf.data  = (wr_tgt == cfs_pkg::TGT_DATA) || (wr_tgt == cfs_pkg::TGT_ALL);
                end else begin
                    d.idx = q.prog[IDXW-1:0];
                end
            end
        end

        if (q.fsm == cfs_pkg::CFS_RUN && platform_mgmt_irq_i) begin
            d.mgmt_seen = 1'b1;
        end

        unique case (q.fsm)
            cfs_pkg::CFS_IDLE: begin
            end
            cfs_pkg::CFS_RUN: begin
                // The pending interrupt is sampled only once a line has finished; the management interrupt is latched on any cycle of the pass.
                if (line_done) begin
                    if (op_err_i) begin
                        d.status   = cfs_pkg::ST_ERR;
                        d.fsm      = cfs_pkg::CFS_IDLE;
                        d.op_valid = 1'b0;
                    end else if (q.idx == IDX_LAST) begin
                        d.status   = (q.mgmt_seen || platform_mgmt_irq_i) ?
                                     cfs_pkg::ST_MGMT : cfs_pkg::ST_OK;
                        d.fsm      = cfs_pkg::CFS_IDLE;
                        d.op_valid = 1'b0;
                    end else if (q.poll && irq_pending_i) begin
                        d.status   = cfs_pkg::ST_IRQ;
                        d.prog     = cfs_pkg::PROG_W'(q.idx) + 64'h1;
                        d.vector   = irq_vector_i;
                        d.irq_ack  = 1'b1;
                        d.fsm      = cfs_pkg::CFS_IDLE;
                        d.op_valid = 1'b0;
                    end else begin
                        d.idx = q.idx + IDXW'(1);
                    end
                end
            end
        endcase

        // Busy is its own flop so that busy_o carries no decode behind it.
        d.busy = (d.fsm == cfs_pkg::CFS_RUN);
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            q         <= '0;
            q.waitreq <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata_o    = q.rdata;
    assign avs_waitrequest_o = q.waitreq;
    assign op_valid_o        = q.op_valid;
    assign op_index_o        = q.idx;
    assign op_o              = q.op;
    assign pf_flush_o        = q.pf;
    assign irq_ack_o         = q.irq_ack;
    assign busy_o            = q.busy;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    bad_target_a: assert property (
        start_go && !tgt_ok |=> q.status == cfs_pkg::ST_BADARG && !busy_o
    ) else $error("reserved target not rejected");

    unified_sel_a: assert property (
        op_valid_o |-> op_o.sel_ucache
    ) else $error("unified cache not selected");

    data_target_a: assert property (
        start_go && tgt_ok && prog_ok && wr_tgt == cfs_pkg::TGT_DATA
        |=> op_valid_o && !op_o.sel_icache && op_o.sel_dcache
    ) else $error("data target selects wrong arrays");

    cohere_inv_a: assert property (
        op_valid_o && q.tgt == cfs_pkg::TGT_COHERE |-> !op_o.inv_data
    ) else $error("coherency target invalidates data");

    broadcast_a: assert property (
        op_valid_o && (op_o.sel_dcache || op_o.sel_ucache) |-> op_o.bcast_data
    ) else $error("data flush not broadcast");

    inv_follow_a: assert property (
        op_valid_o && q.tgt != cfs_pkg::TGT_COHERE |-> op_o.inv_data == q.inv
    ) else $error("invalidate bit not followed");

    no_poll_a: assert property (
        line_done && !op_err_i && !q.poll && q.idx != IDX_LAST
        |=> busy_o && op_valid_o && op_index_o == $past(q.idx) + IDXW'(1)
    ) else $error("pass left early without polling");

    irq_stop_a: assert property (
        line_done && !op_err_i && q.poll && irq_pending_i && q.idx != IDX_LAST
        |=> !busy_o && irq_ack_o && q.status == cfs_pkg::ST_IRQ
            && q.vector == $past(irq_vector_i)
            && q.prog == cfs_pkg::PROG_W'($past(q.idx)) + 64'h1
            ##1 !irq_ack_o
    ) else $error("interrupt stop malformed");

    zero_start_a: assert property (
        start_go && tgt_ok && q.prog == '0
        |=> busy_o && op_index_o == '0 && pf_flush_o.instr == ($past(wr_tgt) != cfs_pkg::TGT_DATA)
    ) else $error("zero start did not reset pass");

    done_status_a: assert property (
        line_done && !op_err_i && q.idx == IDX_LAST
        |=> !busy_o && (q.status == (($past(q.mgmt_seen) || $past(platform_mgmt_irq_i)) ?
                                     cfs_pkg::ST_MGMT : cfs_pkg::ST_OK))
    ) else $error("completion status wrong");

    err_status_a: assert property (
        line_done && op_err_i |=> !busy_o && q.status == cfs_pkg::ST_ERR
    ) else $error("error status not reported");

    bus_answer_a: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o
    ) else $error("bus answer timing wrong");

    // These checks trust the caller's resume rule: a forged position inside
    // the index range is taken as it stands and cannot be told apart.
    wait_state_a: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o
    ) else $error("waitrequest low for more than one cycle");

    op_hold_a: assert property (
        op_valid_o && !op_ack_i |=> op_valid_o && $stable(op_index_o) && $stable(op_o)
    ) else $error("line request changed before ack");

    instr_target_a: assert property (
        start_go && tgt_ok && prog_ok && wr_tgt == cfs_pkg::TGT_INSTR
        |=> op_valid_o && op_o.sel_icache && !op_o.sel_dcache
    ) else $error("instruction target selects wrong arrays");

    all_target_a: assert property (
        start_go && tgt_ok && prog_ok && wr_tgt == cfs_pkg::TGT_ALL
        |=> op_valid_o && op_o.sel_icache && op_o.sel_dcache
    ) else $error("all target selects wrong arrays");

    cohere_target_a: assert property (
        start_go && tgt_ok && prog_ok && wr_tgt == cfs_pkg::TGT_COHERE
        |=> op_valid_o && op_o.sel_icache && op_o.inv_icache && !op_o.inv_data
    ) else $error("coherency target selects wrong arrays");

    resume_idx_a: assert property (
        start_go && tgt_ok && prog_ok && q.prog != '0
        |=> busy_o && op_index_o == $past(q.prog[IDXW-1:0]) && pf_flush_o == '0
    ) else $error("resume did not start at position");

    bad_prog_a: assert property (
        start_go && !prog_ok |=> q.status == cfs_pkg::ST_BADARG && !busy_o
    ) else $error("bad position not rejected");

    pf_data_a: assert property (
        start_go && tgt_ok && q.prog == '0
        |=> pf_flush_o.data == ($past(wr_tgt) == cfs_pkg::TGT_DATA
                                || $past(wr_tgt) == cfs_pkg::TGT_ALL)
    ) else $error("data prefetch cancel wrong");

    pf_pulse_a: assert property (
        pf_flush_o != '0 |=> pf_flush_o == '0
    ) else $error("prefetch cancel not a pulse");

    poll_only_a: assert property (
        irq_ack_o |-> q.poll && q.prog != '0 && prog_ok
    ) else $error("interrupt taken without polling");

    mgmt_sticky_a: assert property (
        busy_o && platform_mgmt_irq_i |=> q.mgmt_seen
    ) else $error("management interrupt not kept");

    ack_idle_a: assert property (
        !busy_o && !start_go && op_ack_i |=> !busy_o && $stable(q.status)
    ) else $error("line ack outside a pass taken");

    cmd_busy_a: assert property (
        wr_go && avs_address_i == cfs_pkg::OFS_CMD && busy_o |=> $stable(op_o)
    ) else $error("command accepted during a pass");

    cov_irq_stop_c:  cover property (line_done && q.poll && irq_pending_i && q.idx != IDX_LAST);
    cov_complete_c:  cover property (line_done && !op_err_i && q.idx == IDX_LAST && !q.mgmt_seen);
    cov_mgmt_done_c: cover property (line_done && !op_err_i && q.idx == IDX_LAST && q.mgmt_seen);
    cov_bad_arg_c:   cover property (start_go && !tgt_ok);
    cov_resume_c:    cover property (start_go && tgt_ok && prog_ok && q.prog != '0);

endmodule

// ==== rtl/cfs_pkg.sv ====
package cfs_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] OFS_CMD     = 5'h00;
    localparam logic [4:0] OFS_PROG_LO = 5'h04;
    localparam logic [4:0] OFS_PROG_HI = 5'h08;
    localparam logic [4:0] OFS_STATUS  = 5'h0c;
    localparam logic [4:0] OFS_VECTOR  = 5'h10;

    // Command word layout.
    localparam int unsigned CMD_TGT_LSB  = 0;
    localparam int unsigned CMD_TGT_W    = 8;
    localparam int unsigned CMD_INV_BIT  = 8;
    localparam int unsigned CMD_POLL_BIT = 9;

    // Status word layout.
    localparam int unsigned STAT_CODE_W   = 8;
    localparam int unsigned STAT_BUSY_BIT = 8;
    localparam int unsigned STAT_MGMT_BIT = 9;
    localparam int unsigned VEC_W         = 8;
    localparam int unsigned PROG_W        = 64;

    // Flush target selector codes.
    localparam logic [7:0] TGT_INSTR  = 8'h01;
    localparam logic [7:0] TGT_DATA   = 8'h02;
    localparam logic [7:0] TGT_ALL    = 8'h03;
    localparam logic [7:0] TGT_COHERE = 8'h04;

    // Return status codes, two's complement in eight bits.
    localparam logic [7:0] ST_OK     = 8'h00;
    localparam logic [7:0] ST_IRQ    = 8'h01;
    localparam logic [7:0] ST_MGMT   = 8'h02;
    localparam logic [7:0] ST_BADARG = 8'hfe;
    localparam logic [7:0] ST_ERR    = 8'hfd;

    typedef enum logic {
        CFS_IDLE = 1'b0,
        CFS_RUN  = 1'b1
    } cfs_fsm_t;

    // One per-line request to the cache arrays.
    typedef struct packed {
        logic sel_icache;
        logic sel_dcache;
        logic sel_ucache;
        logic inv_icache;
        logic inv_data;
        logic bcast_data;
        logic bcast_icache;
    } cfs_line_op_t;

    typedef struct packed {
        logic instr;
        logic data;
    } cfs_pf_flush_t;

endpackage

// ==== dv/cfs_line_mem_model.sv ====
`timescale 1ns/1ns

// Stands in for the cache arrays and memory behind the line step link.
module cfs_line_mem_model (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       srst_i,
    // Line step link
    input  wire logic       op_valid_i,
    output logic            op_ack_o,
    output logic            op_err_o,
    // Bench control
    input  wire logic [1:0] delay_i,
    input  wire logic       err_i,
    output int              lines_o
);
    logic [1:0] cnt_q;
    logic       junk_q;

    // Outside an ack the error line toggles, so a design that reads it there gets no help.
    assign op_err_o = op_ack_o ? err_i : junk_q;

    always_ff @(posedge ref_clk_i) begin
        op_ack_o <= 1'b0;
        junk_q   <= ~junk_q;
        if (srst_i) begin
            cnt_q   <= 2'h0;
            junk_q  <= 1'b0;
            lines_o <= 0;
        end else begin
            if (op_ack_o) begin
                lines_o <= lines_o + 1;
            end
            if (op_valid_i && !op_ack_o) begin
                if (cnt_q == delay_i) begin
                    op_ack_o <= 1'b1;
                    cnt_q    <= 2'h0;
                end else begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end
        end
    end
endmodule

// ==== dv/cfs_cache_flush_sequencer_tb.sv ====
`timescale 1ns/1ns

module cfs_cache_flush_sequencer_tb;
    typedef struct {
        string       name;
        logic [31:0] exp;
        logic [31:0] mask;
    } cfs_note_t;

    logic                  ref_clk_i = 1'b0;
    logic                  srst_i = 1'b1;
    logic [4:0]            addr = 5'h00;
    logic                  rd = 1'b0;
    logic                  wr = 1'b0;
    logic [31:0]           wdata = 32'h0;
    logic [31:0]           rdata;
    logic                  wreq;
    logic                  op_valid;
    logic [1:0]            op_index;
    cfs_pkg::cfs_line_op_t op;
    cfs_pkg::cfs_line_op_t exp_op;
    cfs_pkg::cfs_pf_flush_t pf;
    cfs_pkg::cfs_pf_flush_t exp_pf;
    logic                  op_ack;
    logic                  op_err;
    logic                  irq_pend = 1'b0;
    logic [7:0]            irq_vec = 8'h00;
    logic [7:0]            vec;
    logic                  irq_ack;
    logic                  mgmt_irq = 1'b0;
    logic                  busy;
    logic                  vld_q = 1'b0;
    logic [1:0]            delay = 2'h0;
    logic                  err_cmd = 1'b0;
    logic [7:0]            bad [4] = '{8'h00, 8'h05, 8'hff, cfs_pkg::TGT_ALL};
    int                    lines;
    int                    checks = 0;
    int                    mismatches = 0;
    int                    seed = 90129;
    int                    pf_cnt = 0;
    int                    irq_cnt = 0;
    int                    exp_idx = 0;
    int                    l0;
    int                    p0;
    cfs_note_t             notes [$];
    cfs_note_t             n;

    cfs_cache_flush_sequencer #(.SETS(2), .WAYS(2)) i_cfs_cache_flush_sequencer (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .op_valid_o(op_valid),
        .op_index_o(op_index), .op_o(op), .op_ack_i(op_ack), .op_err_i(op_err),
        .pf_flush_o(pf), .irq_pending_i(irq_pend), .irq_vector_i(irq_vec),
        .irq_ack_o(irq_ack), .platform_mgmt_irq_i(mgmt_irq), .busy_o(busy));

    cfs_line_mem_model i_cfs_line_mem_model (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .op_valid_i(op_valid), .op_ack_o(op_ack),
        .op_err_o(op_err), .delay_i(delay), .err_i(err_cmd), .lines_o(lines));

    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Each access ends one edge after the release, so no strobe is set twice in one step.
    task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        do @(posedge ref_clk_i); while (wreq);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic bus_rd(logic [4:0] a, string name, logic [31:0] exp, logic [31:0] mask);
        notes.push_back('{name, exp, mask});
        bus(1'b0, a, 32'h0);
    endtask

    task automatic start(logic [7:0] t, logic inv, logic poll, logic [31:0] prog);
        exp_idx = prog;
        exp_op = '{t != cfs_pkg::TGT_DATA, t != cfs_pkg::TGT_INSTR, 1'b1, 1'b1,
                   inv && t != cfs_pkg::TGT_COHERE, 1'b1, 1'b0};
        exp_pf = '{t != cfs_pkg::TGT_DATA, t == cfs_pkg::TGT_DATA || t == cfs_pkg::TGT_ALL};
        l0 = lines;
        p0 = pf_cnt;
        bus(1'b1, cfs_pkg::OFS_PROG_LO, prog);
        bus(1'b1, cfs_pkg::OFS_PROG_HI, 32'h0);
        bus(1'b1, cfs_pkg::OFS_CMD, {22'h0, poll, inv, t});
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        while ((busy || k < 2) && k < 400) begin
            @(posedge ref_clk_i);
            k++;
        end
        check("pass ends", 32'(k < 400), 32'h1);
    endtask

    task automatic run(logic [7:0] t, logic inv, logic poll, logic [31:0] prog);
        start(t, inv, poll, prog);
        wait_idle();
    endtask

    // Read data is judged against the notes the driver left, line steps against exp_op and exp_idx.
    always @(posedge ref_clk_i) begin
        vld_q <= op_valid;
        if (rd && !wreq && notes.size() > 0) begin
            n = notes.pop_front();
            check(n.name, rdata & n.mask, n.exp);
        end
        if (op_valid && !vld_q) check("line op", {25'h0, op}, {25'h0, exp_op});
        if (pf != 2'h0) begin
            pf_cnt++;
            check("prefetch", {30'h0, pf}, {30'h0, exp_pf});
        end
        if (irq_ack) irq_cnt++;
        if (op_valid && op_ack) begin
            check("index", {30'h0, op_index}, 32'(exp_idx));
            exp_idx++;
        end
    end

    initial begin
        repeat (30000) @(posedge ref_clk_i);
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(posedge ref_clk_i);
        bus_rd(cfs_pkg::OFS_STATUS, "status", 32'h0, 32'h3ff);
        bus_rd(cfs_pkg::OFS_PROG_LO, "prog", 32'h0, 32'hffffffff);
        bus_rd(5'h14, "unmapped", 32'h0, 32'hffffffff);
        $display("test reset done");
        for (int t = 1; t <= 4; t++) begin
            for (int i = 0; i < 2; i++) begin
                delay <= 2'($random(seed));
                run(8'(t), 1'(i), 1'b0, 32'h0);
                check("lines", 32'(lines - l0), 32'h4);
                check("prefetch pulses", 32'(pf_cnt - p0), 32'h1);
                bus_rd(cfs_pkg::OFS_CMD, "cmd", {22'h0, 1'b0, 1'(i), 8'(t)}, 32'h3ff);
                bus_rd(cfs_pkg::OFS_STATUS, "status", 32'h0, 32'h3ff);
            end
        end
        $display("test targets done");
        for (int i = 0; i < 4; i++) begin
            run(bad[i], 1'b0, 1'b0, i == 3 ? 32'h4 : 32'h0);
            bus_rd(cfs_pkg::OFS_STATUS, "status", 32'hfe, 32'h3ff);
            check("lines", 32'(lines - l0), 32'h0);
        end
        $display("test reserved done");
        vec = 8'($random(seed));
        irq_vec <= vec;
        irq_pend <= 1'b1;
        run(cfs_pkg::TGT_ALL, 1'b1, 1'b0, 32'h0);
        check("lines", 32'(lines - l0), 32'h4);
        bus_rd(cfs_pkg::OFS_STATUS, "status", 32'h0, 32'h3ff);
        check("irq taken", 32'(irq_cnt), 32'h0);
        run(cfs_pkg::TGT_ALL, 1'b1, 1'b1, 32'h0);
        check("lines", 32'(lines - l0), 32'h1);
        bus_rd(cfs_pkg::OFS_STATUS, "status", 32'h1, 32'h3ff);
        bus_rd(cfs_pkg::OFS_PROG_LO, "prog", 32'h1, 32'hffffffff);
        bus_rd(cfs_pkg::OFS_PROG_HI, "prog hi", 32'h0, 32'hffffffff);
        bus_rd(cfs_pkg::OFS_VECTOR, "vector", {24'h0, vec}, 32'hff);
        check("irq taken", 32'(irq_cnt), 32'h1);
        irq_pend <= 1'b0;
        run(cfs_pkg::TGT_ALL, 1'b1, 1'b1, 32'h1);
        check("lines", 32'(lines - l0), 32'h3);
        check("prefetch pulses", 32'(pf_cnt - p0), 32'h0);
        bus_rd(cfs_pkg::OFS_STATUS, "status", 32'h0, 32'h3ff);
        $display("test interrupt done");
        delay <= 2'h3;
        start(cfs_pkg::TGT_DATA, 1'b0, 1'b0, 32'h0);
        mgmt_irq <= 1'b1;
        bus(1'b1, cfs_pkg::OFS_CMD, 32'h0);
        mgmt_irq <= 1'b0;
        wait_idle();
        bus_rd(cfs_pkg::OFS_STATUS, "status", 32'h202, 32'h3ff);
        bus_rd(cfs_pkg::OFS_CMD, "cmd", {24'h0, cfs_pkg::TGT_DATA}, 32'h3ff);
        run(cfs_pkg::TGT_DATA, 1'b0, 1'b0, 32'h0);
        bus_rd(cfs_pkg::OFS_STATUS, "status", 32'h0, 32'h3ff);
        err_cmd <= 1'b1;
        run(cfs_pkg::TGT_INSTR, 1'b0, 1'b0, 32'h0);
        err_cmd <= 1'b0;
        check("lines", 32'(lines - l0), 32'h1);
        bus_rd(cfs_pkg::OFS_STATUS, "status", 32'hfd, 32'h3ff);
        $display("test mgmt and error done");
        start(cfs_pkg::TGT_ALL, 1'b0, 1'b1, 32'h0);
        srst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(posedge ref_clk_i);
        check("busy after reset", 32'(busy), 32'h0);
        bus_rd(cfs_pkg::OFS_STATUS, "status", 32'h0, 32'h3ff);
        bus_rd(cfs_pkg::OFS_PROG_LO, "prog", 32'h0, 32'hffffffff);
        $display("test mid reset done");
        end_sim();
    end
endmodule
